// file: bench/backplane_bus_arbiter_bench.sv
// self-checking bench for the slot-1 arbiter
`default_nettype none
module backplane_bus_arbiter_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, mute, ce;
	logic [1:0] form, ptr;
	logic [3:0] load, mirror;
	logic [2:0] lag;
	wire logic [3:0] req_n, grant_n;
	wire logic busy_n, clear_n, owner, tmo, won;
	wire logic [1:0] lvl;
	int err_total, checked;
	backplane_bus_arbiter #(.TIMEOUT_CYC(8)) i_backplane_bus_arbiter (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(ce), .i_form(form),
		.i_req_n(req_n), .i_busy_n(busy_n), .o_grant_n(grant_n),
		.o_clear_n(clear_n), .o_owner_valid(owner), .o_timeout(tmo));
	requester_model i_requester_model (.i_ref_clk(clk), .i_rst_n(rst_n),
		.i_grant_n(grant_n), .i_load(load), .i_mute(mute), .i_lag(lag),
		.o_req_n(req_n), .o_busy_n(busy_n), .o_won(won), .o_lvl(lvl));
	////////////////////////////////////////////////////////////////////////
	task check(string what, logic [3:0] seen, logic [3:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// rotating scans down from one below the last level, wrapping
	function logic [1:0] pick(logic [3:0] m);
		for (int i = 1; i <= 4; i++)
			if (form == arb_pkg::FORM_ROTATE && m[ptr - 2'(i)]) return ptr - 2'(i);
		for (int i = 3; i >= 0; i--)
			if (form != arb_pkg::FORM_ROTATE && m[i]) return 2'(i);
		return 2'h0;
	endfunction
	// bounded wait for a requester to win the bus
	task wait_won;
		int n;
		for (n = 0; n < 300 && won !== 1'b1; n++) @(negedge clk);
		if (n == 300) begin
			err_total++;
			complete_run();
		end
	endtask
	// load requests, add late ones one cycle later, before the first grant, drain all (only level 3 in single form)
	task round(logic [3:0] m, logic [3:0] late);
		logic [1:0] e;
		logic [3:0] live;
		// late requests only tracked after a first win, so never alone
		if (m == 4'h0) begin
			m = late;
			late = 4'h0;
		end
		lag = 3'($urandom_range(0, 3));
		load = m;
		@(negedge clk) load = late;
		mirror |= m;
		live = (form == arb_pkg::FORM_SINGLE) ? (mirror & 4'h8) : mirror;
		while (live != 4'h0) begin
			e = pick(live);
			wait_won();
			check("level", {2'h0, lvl}, {2'h0, e});
			check("grant", grant_n, ~(4'h1 << e));
			ptr = e;
			mirror[e] = 1'b0;
			mirror |= late;
			late = 4'h0;
			@(negedge clk) load = 4'h0;
			repeat (10) @(negedge clk);
			check("owner", {3'h0, owner}, 4'h1);
			if (form == arb_pkg::FORM_FIXED)
				check("clear", {3'h0, clear_n}, {3'h0, (mirror >> e) < 4'h2});
			if (form == arb_pkg::FORM_ROTATE)
				check("clear", {3'h0, clear_n},
					{3'h0, (mirror & ~(4'h1 << e)) == 4'h0});
			if (form == arb_pkg::FORM_SINGLE)
				check("single clear", {3'h0, clear_n}, 4'h1);
			live = (form == arb_pkg::FORM_SINGLE) ? (mirror & 4'h8) : mirror;
		end
		repeat (40) @(negedge clk);
		check("idle grant", grant_n, 4'hf);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		{rst_n, mute, ce, load, lag, mirror, err_total, checked} = '0;
		form = arb_pkg::FORM_ROTATE;
		ptr = arb_pkg::TOP_LEVEL;
		void'($urandom(32'hed12));
		repeat (10) @(negedge clk);
		check("reset grant", {grant_n[3:1], clear_n}, 4'hf);
		rst_n = 1'b1;
		// enable low: a pending request must not move any state
		load = 4'h4;
		repeat (12) @(negedge clk);
		check("frozen", grant_n, 4'hf);
		ce = 1'b1;
		round(4'h4, 4'h0);
		round(4'hf, 4'h0);
		repeat (6) round(4'($urandom), 4'($urandom));
		form = arb_pkg::FORM_FIXED;
		round(4'h1, 4'h8);
		repeat (6) round(4'($urandom), 4'($urandom));
		// nobody answers: the grant must be withdrawn with a pulse
		mute = 1'b1;
		load = 4'h2;
		for (int n = 0; n < 40 && tmo !== 1'b1; n++) @(negedge clk);
		check("timeout", {3'h0, tmo}, 4'h1);
		check("withdrawn", grant_n, 4'hf);
		mute = 1'b0;
		// the unanswered level 1 request is still pending and must drain
		round(4'h2, 4'h0);
		form = arb_pkg::FORM_SINGLE;
		round(4'hf, 4'h0);
		check("low levels", {1'b0, grant_n[2:0]}, 4'h7);
		complete_run();
	end
endmodule // backplane_bus_arbiter_bench
`default_nettype wire

// file: bench/requester_model.sv
// behavioural requester boards, one per level, on the grant chains
`default_nettype none
module requester_model (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_grant_n,
	input wire logic [3:0] i_load,
	input wire logic i_mute,
	input wire logic [2:0] i_lag,
	output logic [3:0] o_req_n,
	output logic o_busy_n,
	output logic o_won,
	output logic [1:0] o_lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	// whole cycles, so the 90 ns busy minimum is always covered
	localparam int HOLD = 24;
	logic [3:0] pend_reg;
	logic [3:0] hit;
	logic [1:0] sel;
	logic own_reg;
	int cnt_reg;
	int lag_reg;
	// a grant reaching no pending board runs off the chain end
	always_comb begin
		hit = ~i_grant_n & pend_reg;
		sel = 2'h0;
		for (int i = 0; i < 4; i++)
			if (hit[i]) sel = 2'(i);
	end
	assign o_req_n = ~pend_reg;
	// take a grant, pull busy low, drop the request, hold, release
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pend_reg <= 4'h0;
			own_reg <= 1'b0;
			o_busy_n <= 1'b1;
			o_won <= 1'b0;
			o_lvl <= 2'h0;
			cnt_reg <= 0;
			lag_reg <= 0;
		end else begin
			o_won <= 1'b0;
			pend_reg <= pend_reg | i_load;
			if (own_reg) begin
				cnt_reg <= cnt_reg + 1;
				if (cnt_reg >= HOLD && i_grant_n[o_lvl]) begin
					own_reg <= 1'b0;
					o_busy_n <= 1'b1;
				end
			end else if (!i_mute && hit != 4'h0) begin
				if (lag_reg < int'(i_lag)) lag_reg <= lag_reg + 1;
				else begin
					lag_reg <= 0;
					own_reg <= 1'b1;
					cnt_reg <= 0;
					o_busy_n <= 1'b0;
					o_won <= 1'b1;
					o_lvl <= sel;
					pend_reg <= (pend_reg | i_load) & ~(4'h1 << sel);
				end
			end
		end
	end
endmodule // requester_model
`default_nettype wire

// file: rtl/backplane_bus_arbiter.sv
// slot-1 arbiter driving grant chains and bus clear from request and busy lines
`default_nettype none

// Notes on behaviour
// - boards forward a low grant unless requesting on that level.
// - granted requester pulls busy low, owns bus until releasing it.
// - all mandatory outputs actively driven; inputs monitored.
// - same-level requesters ranked by slot via the grant chain.
// - owner holds busy low until its grant input returns high.
// - owner holds busy low for a minimum pulse width.
module backplane_bus_arbiter #(
	parameter int TIMEOUT_CYC = arb_pkg::GRANT_TIMEOUT_CYC,
	parameter bit USE_TIMEOUT = 1'b1,
	parameter bit ROTATE_CLEAR = 1'b1
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [1:0] i_form,
	input wire logic [3:0] i_req_n,
	input wire logic i_busy_n,
	output logic [3:0] o_grant_n,
	output logic o_clear_n,
	output logic o_owner_valid,
	output logic o_timeout
);

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_GRANT = 3'h2,
		ST_BUSY = 3'h4
	} state_t;

	typedef struct packed {
		logic [3:0] req_meta;
		logic [3:0] req_sync;
		logic busy_meta;
		logic busy_sync;
		logic busy_last;
		state_t state;
		logic [1:0] level;
		logic [31:0] timer;
		logic [3:0] grant_n;
		logic clear_n;
		logic owner_valid;
		logic timeout;
	} arb_t;

	arb_t cur_reg;
	arb_t cur_next;

	// level index of the highest set bit, fixed order 3 down to 0
	function automatic logic [1:0] top_pending(input logic [3:0] req);
		logic [1:0] lvl;
		lvl = 2'h0;
		for (int i = 0; i < arb_pkg::LEVELS; i++) begin
			if (req[i]) begin
				lvl = 2'(i);
			end
		end
		return lvl;
	endfunction

	// first pending level scanning down from start-1 with wrap
	function automatic logic [1:0] rotate_pick(input logic [3:0] req,
			input logic [1:0] start);
		logic [1:0] lvl;
		logic [1:0] probe;
		logic found;
		lvl = start;
		found = 1'b0;
		for (int k = 1; k <= arb_pkg::LEVELS; k++) begin
			probe = start - 2'(k);
			if (!found && req[probe]) begin
				lvl = probe;
				found = 1'b1;
			end
		end
		return lvl;
	endfunction

	// one-hot active-low grant for a level
	function automatic logic [3:0] grant_for(input logic [1:0] lvl);
		return ~(4'h1 << lvl);
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic [3:0] req_live;
	logic busy_live;
	logic [3:0] req_seen;
	logic busy_rise;

	// second flop outputs only; the meta stage feeds nothing else
	always_comb begin
		req_live = ~cur_reg.req_sync;
		busy_live = ~cur_reg.busy_sync;
		// single form ignores levels 0..2 entirely
		if (cur_reg.state == ST_IDLE && i_form == arb_pkg::FORM_SINGLE) begin
			req_seen = req_live & 4'h8;
		end else if (i_form == arb_pkg::FORM_SINGLE) begin
			req_seen = req_live & 4'h8;
		end else begin
			req_seen = req_live;
		end
		// rise found on synced samples only, never on the raw pin
		busy_rise = cur_reg.busy_sync & ~cur_reg.busy_last;
	end

	////////////////////////////////////////////////////////////////////////
	// next-state logic for the whole arbiter
	always_comb begin
		cur_next = cur_reg;
		// two-stage synchronisers on async backplane lines
		cur_next.req_meta = i_req_n;
		cur_next.req_sync = cur_reg.req_meta;
		cur_next.busy_meta = i_busy_n;
		cur_next.busy_sync = cur_reg.busy_meta;
		cur_next.busy_last = cur_reg.busy_sync;
		cur_next.timeout = 1'b0;
		case (cur_reg.state)
			ST_IDLE: begin
				// busy high and a request in the synchronised sample, two cycles behind the pins
				if (!busy_live && req_seen != 4'h0) begin
					if (i_form == arb_pkg::FORM_ROTATE) begin
						cur_next.level = rotate_pick(req_seen, cur_reg.level);
					end else begin
						cur_next.level = top_pending(req_seen);
					end
					cur_next.state = ST_GRANT;
					cur_next.timer = 32'h0;
				end
			end
			ST_GRANT: begin
				// hold grant until owner shows busy low or the grant timeout runs out
				if (busy_live) begin
					cur_next.state = ST_BUSY;
				end else if (USE_TIMEOUT &&
						cur_reg.timer >= 32'(TIMEOUT_CYC - 1)) begin
					// nobody answered: withdraw the grant
					cur_next.state = ST_IDLE;
					cur_next.timeout = 1'b1;
				end else begin
					cur_next.timer = cur_reg.timer + 32'h1;
				end
			end
			ST_BUSY: begin
				// only busy going high again frees the next grant
				if (busy_rise) begin
					cur_next.state = ST_IDLE;
				end
			end
			default: begin
				cur_next.state = ST_IDLE;
			end
		endcase
		// grant driven only in grant state; chain resolves ties
		if (cur_next.state == ST_GRANT) begin
			cur_next.grant_n = grant_for(cur_next.level);
		end else begin
			cur_next.grant_n = arb_pkg::ALL_HIGH;
		end
		// single form never lowers levels 0..2
		if (i_form == arb_pkg::FORM_SINGLE) begin
			cur_next.grant_n[2:0] = 3'h7;
		end
		cur_next.owner_valid = (cur_next.state == ST_BUSY);
		// bus clear: fixed form on higher request, rotating on any other
		cur_next.clear_n = 1'b1;
		if (cur_reg.state != ST_IDLE) begin
			if (i_form == arb_pkg::FORM_FIXED) begin
				if ((req_seen >> cur_reg.level) > 4'h1) begin
					cur_next.clear_n = 1'b0;
				end
			end else if (i_form == arb_pkg::FORM_ROTATE && ROTATE_CLEAR) begin
				if ((req_seen & grant_for(cur_reg.level)) != 4'h0) begin
					cur_next.clear_n = 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register; reset parks lines high, pointer at level 3
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cur_reg <= '{req_meta: 4'hf, req_sync: 4'hf, busy_meta: 1'b1,
				busy_sync: 1'b1, busy_last: 1'b1, state: ST_IDLE,
				level: arb_pkg::TOP_LEVEL, timer: 32'h0, grant_n: 4'hf,
				clear_n: 1'b1, owner_valid: 1'b0, timeout: 1'b0};
		end else if (i_clk_en) begin
			cur_reg <= cur_next;
		end
	end

	assign o_grant_n = cur_reg.grant_n;
	assign o_clear_n = cur_reg.clear_n;
	assign o_owner_valid = cur_reg.owner_valid;
	assign o_timeout = cur_reg.timeout;

	////////////////////////////////////////////////////////////////////////
	// checks on the arbiter's own state and outputs
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_granting;
		cur_reg.state == ST_GRANT;
	endsequence

	a_grant_one_hot: assert property (
		$countones(~o_grant_n) <= 1)
		else $error("more than one grant low");
	a_single_low_high: assert property (
		i_form == arb_pkg::FORM_SINGLE |-> o_grant_n[2:0] == 3'h7)
		else $error("single form lowered level 0..2 grant");
	a_single_only_top: assert property (
		i_clk_en && i_form == arb_pkg::FORM_SINGLE
		&& cur_reg.state == ST_IDLE |=> cur_reg.state != ST_GRANT
		|| cur_reg.level == 2'h3)
		else $error("single form granted a low level");
	a_no_regrant_busy: assert property (
		cur_reg.state == ST_BUSY && busy_live |=> cur_reg.state != ST_GRANT)
		else $error("new grant while bus busy");
	a_grant_matches: assert property (
		i_clk_en and s_granting |=> o_grant_n == grant_for(cur_reg.level)
		|| i_form == arb_pkg::FORM_SINGLE || cur_reg.state != ST_GRANT)
		else $error("grant line does not match level");
	a_fixed_top_pick: assert property (
		i_clk_en && cur_reg.state == ST_IDLE && !busy_live && req_seen != 0
		&& i_form == arb_pkg::FORM_FIXED
		|=> cur_reg.level == top_pending($past(req_seen)))
		else $error("fixed form picked a lower level");
	a_clear_idle_high: assert property (
		i_clk_en && cur_reg.state == ST_IDLE |=> o_clear_n)
		else $error("bus clear low with no owner");
	a_timeout_drop: assert property (
		o_timeout |-> o_grant_n == arb_pkg::ALL_HIGH)
		else $error("grant still low after timeout");
	a_owner_after_busy: assert property (
		(i_clk_en and s_granting) ##0 busy_live |=> o_owner_valid)
		else $error("owner not flagged after busy low");

endmodule : backplane_bus_arbiter
`default_nettype wire

// file: shared/arb_pkg.sv
// constants shared by the backplane arbiter
`default_nettype none
package arb_pkg;
	// scheduling forms
	localparam logic [1:0] FORM_FIXED = 2'h0;
	localparam logic [1:0] FORM_ROTATE = 2'h1;
	localparam logic [1:0] FORM_SINGLE = 2'h2;
	// number of request/grant levels and the highest level index
	localparam int LEVELS = 4;
	localparam logic [1:0] TOP_LEVEL = 2'h3;
	// clock period and grant timeout
	localparam int CLK_PERIOD_NS = 4;
	localparam int GRANT_TIMEOUT_NS = 2000;
	localparam int GRANT_TIMEOUT_CYC = GRANT_TIMEOUT_NS / CLK_PERIOD_NS;
	// every grant line released high
	localparam logic [3:0] ALL_HIGH = 4'hf;
endpackage : arb_pkg
`default_nettype wire
